// File: hdl/iobd_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "iobd_regs.svh"

// Functional notes
// - decode acia at D1C0, general latches at D1E0, ram window at D600.
// - ram window spans 256 bytes to D6FF, each byte reaches on-board ram.
// - acia and latch areas hold four registers, each with seven shadows.
// - acia dsr, cts and dcd inputs held low, always asserted.
// - true external dcd, dsr, cts return on low three bits of D1E3.
// - modem bits read true-sense; asserted dcd reads one on bit 1.
// - status readable at alias D1FF; bit 3 printer irq, bit 4 combined irq.
module iobd_decode (
    input  wire logic                    clk,
    input  wire logic                    arst_n,
    input  wire logic [15:0]             addr,
    input  wire iobd_pkg::iobd_byte_type wdata,
    input  wire logic                    wr,
    input  wire logic                    rd,
    output var  iobd_pkg::iobd_byte_type rdata,
    output var  logic                    acia_cs,
    output var  logic [1:0]              acia_rs,
    output var  logic                    acia_we,
    output var  logic                    acia_re,
    input  wire iobd_pkg::iobd_byte_type acia_rdata,
    input  wire logic                    acia_irq,
    output var  logic                    acia_dsr_n,
    output var  logic                    acia_cts_n,
    output var  logic                    acia_dcd_n,
    input  wire logic                    modem_dcd,
    input  wire logic                    modem_dsr,
    input  wire logic                    modem_cts,
    input  wire logic                    prn_busy_irq,
    output var  logic [11:0]             ram_page,
    output var  logic                    ram_en,
    output var  iobd_pkg::iobd_byte_type prn_data,
    output var  iobd_pkg::iobd_byte_type rom_bank,
    output var  logic                    irq
);
    import iobd_pkg::*;

    // area decode, shared by the access and the read-back path
    function automatic iobd_area_type area_of(input logic [15:0] a);
        if (a[15:`IOBD_AREA_LSB] == 11'(`IOBD_ACIA_BASE >> `IOBD_AREA_LSB)) begin
            area_of = IOBD_AREA_ACIA;
        end else if (a[15:`IOBD_AREA_LSB] == 11'(`IOBD_LATCH_BASE >> `IOBD_AREA_LSB)) begin
            area_of = IOBD_AREA_LATCH;
        end else if (a[15:`IOBD_RAM_LSB] == 8'(`IOBD_RAM_BASE >> `IOBD_RAM_LSB)) begin
            area_of = IOBD_AREA_RAM;
        end else begin
            area_of = IOBD_AREA_NONE;
        end
    endfunction : area_of

    iobd_area_type   area;
    logic [1:0]      reg_idx;
    logic            latch_wr;
    logic            latch_rd;
    logic            ram_wr;
    logic            irq_clr_wr;
    logic            irq_en_wr;
    logic            irq_stat_rd;
    logic            irq_en_rd;
    logic [2:0]      modem_sync;
    logic [1:0]      irq_sync;
    logic            dcd_s;
    logic            dsr_s;
    logic            cts_s;
    logic            prn_s;
    logic            acia_s;
    iobd_byte_type   modem_status;
    iobd_byte_type   ram_rdata;
    iobd_byte_type   latch_rdata;
    iobd_byte_type   page_q;
    iobd_byte_type   data_q;
    iobd_byte_type   gpio_q;
    iobd_byte_type   rom_q;
    iobd_byte_type   rdata_d;
    iobd_byte_type   rdata_q;
    logic            ram_sel_q;
    logic [2:0]      modem_prev_q;
    logic            prn_prev_q;
    logic            acia_prev_q;
    logic [2:0]      events;
    logic [2:0]      stat_d;
    logic [2:0]      stat_q;
    logic [2:0]      en_q;

    // area and register select
    assign area    = area_of(addr);
    assign reg_idx = addr[1:0];

    // acia strobes pass straight through so the part sees the host cycle itself
    assign acia_cs = (area == IOBD_AREA_ACIA) && (wr || rd);
    assign acia_rs = reg_idx;
    assign acia_we = acia_cs && wr;
    assign acia_re = acia_cs && rd;

    // receiver must never be blocked by modem lines, so hold them asserted
    assign acia_dsr_n = 1'b0;
    assign acia_cts_n = 1'b0;
    assign acia_dcd_n = 1'b0;

    // pin inputs are asynchronous to the host clock
    iobd_sync #(.WIDTH(3)) u_modem_sync (
        .clk      (clk),
        .arst_n   (arst_n),
        .async_in ({modem_cts, modem_dsr, modem_dcd}),
        .sync_out (modem_sync)
    );

    iobd_sync #(.WIDTH(2)) u_irq_sync (
        .clk      (clk),
        .arst_n   (arst_n),
        .async_in ({acia_irq, prn_busy_irq}),
        .sync_out (irq_sync)
    );

    assign dcd_s  = modem_sync[0];
    assign dsr_s  = modem_sync[1];
    assign cts_s  = modem_sync[2];
    assign prn_s  = irq_sync[0];
    assign acia_s = irq_sync[1];

    // modem status read value, true-sense
    assign modem_status = {3'h0, acia_s || prn_s, prn_s, cts_s, dcd_s, dsr_s};

    // latch area writes and reads
    assign latch_wr = wr && (area == IOBD_AREA_LATCH);
    assign latch_rd = rd && (area == IOBD_AREA_LATCH);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            page_q <= `IOBD_LATCH_RST;
            data_q <= `IOBD_LATCH_RST;
            gpio_q <= `IOBD_LATCH_RST;
            rom_q  <= `IOBD_LATCH_RST;
        end else if (latch_wr) begin
            unique case (reg_idx)
                `IOBD_LREG_PAGE:  page_q <= wdata;
                `IOBD_LREG_DATA:  data_q <= wdata;
                `IOBD_LREG_GPIO:  gpio_q <= wdata;
                `IOBD_LREG_MODEM: rom_q  <= wdata;
            endcase
        end
    end

    assign ram_page = {gpio_q[`IOBD_GP_HIADDR_MSB:0], page_q};
    assign ram_en   = gpio_q[`IOBD_GP_RAMEN];
    assign prn_data = data_q;
    assign rom_bank = rom_q;

    // the latch area reads its own stores except the modem/irq sense word
    assign latch_rdata = (reg_idx == `IOBD_LREG_MODEM) ? modem_status :
                         (reg_idx == `IOBD_LREG_GPIO)  ? gpio_q :
                         (reg_idx == `IOBD_LREG_DATA)  ? data_q : page_q;

    // ram window: every offset 00..FF maps to one byte of the ram
    assign ram_wr = wr && (area == IOBD_AREA_RAM);

    iobd_ram u_ram (
        .clk    (clk),
        .arst_n (arst_n),
        .we     (ram_wr),
        .addr   (addr[7:0]),
        .wdata  (wdata),
        .rdata  (ram_rdata)
    );

    // interrupt block
    assign irq_clr_wr  = wr && (addr == `IOBD_IRQ_CLR);
    assign irq_en_wr   = wr && (addr == `IOBD_IRQ_EN);
    assign irq_stat_rd = rd && (addr == `IOBD_IRQ_STAT);
    assign irq_en_rd   = rd && (addr == `IOBD_IRQ_EN);

    assign events[`IOBD_EV_MODEM] = modem_sync != modem_prev_q;
    assign events[`IOBD_EV_PRN]   = prn_s && !prn_prev_q;
    assign events[`IOBD_EV_ACIA]  = acia_s && !acia_prev_q;

    // a new event in the clear cycle survives the clear
    assign stat_d = (stat_q & ~(irq_clr_wr ? wdata[2:0] : 3'h0)) | events;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            modem_prev_q <= 3'h0;
            prn_prev_q   <= 1'b0;
            acia_prev_q  <= 1'b0;
            stat_q       <= `IOBD_IRQ_RST;
            en_q         <= `IOBD_IRQ_RST;
        end else begin
            modem_prev_q <= modem_sync;
            prn_prev_q   <= prn_s;
            acia_prev_q  <= acia_s;
            stat_q       <= stat_d;
            en_q         <= irq_en_wr ? wdata[2:0] : en_q;
        end
    end

    assign irq = |(stat_q & en_q);

    // read data select; unmapped addresses answer zero
    assign rdata_d = (acia_re)     ? acia_rdata :
                     (latch_rd)    ? latch_rdata :
                     (irq_stat_rd) ? {5'h00, stat_q} :
                     (irq_en_rd)   ? {5'h00, en_q} : 8'h00;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q   <= 8'h00;
            ram_sel_q <= 1'b0;
        end else begin
            rdata_q   <= rdata_d;
            ram_sel_q <= rd && (area == IOBD_AREA_RAM);
        end
    end

    // ram already registers its output, so steer rather than re-register
    assign rdata = ram_sel_q ? ram_rdata : rdata_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    acia_select_a: assert property (
        (wr || rd) && addr[15:5] == 11'h68E |-> acia_cs && !(area == IOBD_AREA_RAM))
        else $error("acia area not selected");

    ram_window_a: assert property (
        (wr && addr[15:8] == 8'hD6) ##1 (rd && addr == $past(addr)) |=> rdata == $past(wdata, 2))
        else $error("ram window byte not returned");

    acia_shadow_a: assert property (
        rd && addr[15:5] == 11'h68E |-> acia_re && acia_rs == addr[1:0] && !acia_we)
        else $error("acia shadow decode wrong");

    modem_hold_a: assert property (
        !acia_dsr_n && !acia_cts_n && !acia_dcd_n)
        else $error("acia modem inputs not held asserted");

    modem_read_a: assert property (
        rd && addr == 16'hD1E3 |=> rdata[2:0] == {$past(cts_s), $past(dcd_s), $past(dsr_s)})
        else $error("modem lines not returned");

    dcd_polarity_a: assert property (
        rd && addr[15:5] == 11'h68F && addr[1:0] == 2'h3 && dcd_s |=> rdata[1])
        else $error("asserted dcd did not read as one");

    alias_status_a: assert property (
        rd && addr == 16'hD1FF |=> rdata[4:3] == {$past(acia_s) || $past(prn_s), $past(prn_s)})
        else $error("alias status bits wrong");

    latch_select_a: assert property (
        wr && addr[15:5] == 11'h68F && addr[1:0] == 2'h0 |=> ram_page[7:0] == $past(wdata))
        else $error("page latch not written by index zero");

    sticky_set_a: assert property (
        events != 3'h0 |=> (stat_q & $past(events)) == $past(events))
        else $error("event lost in status");

    latch_area_a: assert property (
        (wr || rd) && addr[15:5] == 11'h68F |-> !acia_cs)
        else $error("acia selected in latch area");

    acia_idle_a: assert property (
        !wr && !rd |-> !acia_cs && !acia_we && !acia_re)
        else $error("acia strobed without host cycle");

    unmapped_read_a: assert property (
        rd && addr[15:8] != 8'hD1 && addr[15:8] != 8'hD6 |=> rdata == 8'h00)
        else $error("unmapped read not zero");

    ram_isolated_a: assert property (
        wr && addr[15:8] == 8'hD6 |=> $stable(ram_page) && $stable(prn_data) && $stable(rom_bank))
        else $error("ram write disturbed a latch");

    data_shadow_a: assert property (
        wr && addr[15:5] == 11'h68F && addr[1:0] == 2'h1 |=> prn_data == $past(wdata))
        else $error("data latch not written");

    rom_shadow_a: assert property (
        wr && addr[15:5] == 11'h68F && addr[1:0] == 2'h3 |=> rom_bank == $past(wdata))
        else $error("bank latch not written");

    acia_read_a: assert property (
        rd && addr[15:5] == 11'h68E |=> rdata == $past(acia_rdata))
        else $error("acia read data not returned");

    acia_write_a: assert property (
        wr && addr[15:5] == 11'h68E |-> acia_we && !acia_re && acia_rs == addr[1:0])
        else $error("acia write decode wrong");

    dsr_bit_a: assert property (
        rd && addr[15:5] == 11'h68F && addr[1:0] == 2'h3 |=> rdata[0] == $past(dsr_s) && rdata[7:5] == 3'h0)
        else $error("dsr bit or spare bits wrong");

    gp_shadow_a: assert property (
        wr && addr[15:5] == 11'h68F && addr[1:0] == 2'h2 |=>
        ram_page[11:8] == $past(wdata[3:0]) && ram_en == $past(wdata[5]))
        else $error("general latch not written");

    status_read_a: assert property (
        rd && addr == 16'hD100 |=> rdata == {5'h00, $past(stat_q)})
        else $error("status read wrong");

    clear_done_a: assert property (
        wr && addr == 16'hD101 && events == 3'h0 |=> (stat_q & $past(wdata[2:0])) == 3'h0)
        else $error("status bit not cleared");

endmodule : iobd_decode

`default_nettype wire

// File: hdl/iobd_pkg.sv
package iobd_pkg;

    typedef enum logic [1:0] {
        IOBD_AREA_NONE  = 2'b00,
        IOBD_AREA_ACIA  = 2'b01,
        IOBD_AREA_LATCH = 2'b10,
        IOBD_AREA_RAM   = 2'b11
    } iobd_area_type;

    typedef logic [7:0] iobd_byte_type;

endpackage : iobd_pkg

// File: hdl/iobd_ram.sv
`timescale 1ns/1ps
`default_nettype none

module iobd_ram (
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    input  wire logic                  we,
    input  wire logic [7:0]            addr,
    input  wire iobd_pkg::iobd_byte_type wdata,
    output var  iobd_pkg::iobd_byte_type rdata
);
    import iobd_pkg::*;

    // array has no reset: contents are undefined after power-up, as real ram
    iobd_byte_type mem [0:255];
    iobd_byte_type rdata_q;

    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= mem[addr];
        end
    end

    assign rdata = rdata_q;

endmodule : iobd_ram

`default_nettype wire

// File: hdl/iobd_regs.svh
`ifndef IOBD_REGS_SVH
`define IOBD_REGS_SVH

// host address areas
`define IOBD_ACIA_BASE    16'hD1C0
`define IOBD_LATCH_BASE   16'hD1E0
`define IOBD_RAM_BASE     16'hD600
`define IOBD_RAM_LAST     16'hD6FF
`define IOBD_MODEM_ALIAS  16'hD1FF
`define IOBD_AREA_LSB     5
`define IOBD_RAM_LSB      8

// interrupt block, outside every decoded area
`define IOBD_IRQ_STAT     16'hD100
`define IOBD_IRQ_CLR      16'hD101
`define IOBD_IRQ_EN       16'hD102

// register index inside the latch area
`define IOBD_LREG_PAGE    2'h0
`define IOBD_LREG_DATA    2'h1
`define IOBD_LREG_GPIO    2'h2
`define IOBD_LREG_MODEM   2'h3

// modem status bit positions
`define IOBD_MS_DSR       0
`define IOBD_MS_DCD       1
`define IOBD_MS_CTS       2
`define IOBD_MS_PBUSY     3
`define IOBD_MS_BIRQ      4

// general output latch fields
`define IOBD_GP_HIADDR_MSB 3
`define IOBD_GP_RAMEN      5

// event bit positions
`define IOBD_EV_MODEM     0
`define IOBD_EV_PRN       1
`define IOBD_EV_ACIA      2

// reset values
`define IOBD_LATCH_RST    8'h00
`define IOBD_IRQ_RST      3'h0

`endif

// File: hdl/iobd_sync.sv
`timescale 1ns/1ps
`default_nettype none

module iobd_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    import iobd_pkg::*;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            logic meta_q;
            logic hold_q;
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    meta_q <= 1'b0;
                    hold_q <= 1'b0;
                end else begin
                    meta_q <= async_in[g];
                    hold_q <= meta_q;
                end
            end
            assign sync_out[g] = hold_q;
        end
    endgenerate

endmodule : iobd_sync

`default_nettype wire

// File: verif/iobd_acia_model.sv
`timescale 1ns/1ps
`default_nettype none
module iobd_acia_model (
    input  wire logic                    clk,
    input  wire logic                    acia_cs,
    input  wire logic [1:0]              acia_rs,
    input  wire logic                    acia_we,
    input  wire logic                    acia_re,
    input  wire iobd_pkg::iobd_byte_type data_in,
    input  wire logic                    irq_req,
    output var  iobd_pkg::iobd_byte_type acia_rdata,
    output var  logic                    acia_irq
);
    import iobd_pkg::*;
    iobd_byte_type regs_q [4];
    always_ff @(posedge clk) begin
        if (acia_cs && acia_we) begin
            regs_q[acia_rs] <= data_in;
        end
    end
    // outside a read the bus shows the inverse, so a late sample never matches
    assign acia_rdata = (acia_cs && acia_re) ? regs_q[acia_rs] : ~regs_q[acia_rs];
    assign acia_irq   = irq_req;
endmodule : iobd_acia_model
`default_nettype wire

// File: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import iobd_pkg::*;
    logic          clk = 1'b0;
    logic          arst_n = 1'b0;
    logic [15:0]   addr = 16'h0000;
    iobd_byte_type wdata = 8'h00;
    logic          wr = 1'b0;
    logic          rd = 1'b0;
    logic          m_dcd = 1'b0;
    logic          m_dsr = 1'b0;
    logic          m_cts = 1'b0;
    logic          prn_irq = 1'b0;
    logic          a_req = 1'b0;
    iobd_byte_type rdata, acia_rdata, prn_data, rom_bank, v;
    logic          acia_cs, acia_we, acia_re, acia_irq, dsr_n, cts_n, dcd_n, ram_en, irq;
    logic [1:0]    acia_rs;
    logic [11:0]   ram_page;
    int            num_errors = 0;
    int            samples_checked = 0;

    always #25 clk = ~clk;

    iobd_decode i_iobd_decode (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .acia_cs(acia_cs), .acia_rs(acia_rs), .acia_we(acia_we), .acia_re(acia_re),
        .acia_rdata(acia_rdata), .acia_irq(acia_irq), .acia_dsr_n(dsr_n), .acia_cts_n(cts_n),
        .acia_dcd_n(dcd_n), .modem_dcd(m_dcd), .modem_dsr(m_dsr), .modem_cts(m_cts),
        .prn_busy_irq(prn_irq), .ram_page(ram_page), .ram_en(ram_en), .prn_data(prn_data),
        .rom_bank(rom_bank), .irq(irq));

    iobd_acia_model i_iobd_acia_model (.clk(clk), .acia_cs(acia_cs), .acia_rs(acia_rs), .acia_we(acia_we),
        .acia_re(acia_re), .data_in(wdata), .irq_req(a_req), .acia_rdata(acia_rdata), .acia_irq(acia_irq));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic bus_wr(input logic [15:0] a, input iobd_byte_type d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        // latches update at this edge, so let them settle before anyone looks
        @(negedge clk);
    endtask : bus_wr

    // write then read with no gap, as the bus allows
    task automatic bus_wr_rd(input logic [15:0] a, input iobd_byte_type d, output iobd_byte_type q);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        rd    <= 1'b1;
        @(posedge clk);
        rd    <= 1'b0;
        @(negedge clk);
        q = rdata;
    endtask : bus_wr_rd

    task automatic bus_rd(input logic [15:0] a, output iobd_byte_type d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : bus_rd

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : wait_clk

    task automatic test_reset();
        chk({dsr_n, cts_n, dcd_n}, 3'h0);
        chk({irq, ram_en, ram_page}, 14'h0000);
    endtask : test_reset

    task automatic test_ram();
        logic [15:0] a [6] = '{16'hD600, 16'hD601, 16'hD655, 16'hD6AA, 16'hD6FE, 16'hD6FF};
        foreach (a[i]) bus_wr(a[i], a[i][7:0] ^ 8'hC3);
        foreach (a[i]) begin
            bus_rd(a[i], v);
            chk(v, a[i][7:0] ^ 8'hC3);
        end
        bus_wr_rd(16'hD680, 8'h5C, v);
        chk(v, 8'h5C);
        bus_rd(16'hD5FF, v);
        chk(v, 8'h00);
        bus_rd(16'hD700, v);
        chk(v, 8'h00);
    endtask : test_ram

    task automatic test_latch();
        for (int k = 0; k < 8; k++) begin
            bus_wr(16'hD1E0 + 16'(4 * k), 8'h10 + 8'(k));
            bus_rd(16'hD1E0 + 16'(4 * ((k + 3) % 8)), v);
            chk(v, 8'h10 + 8'(k));
            chk(ram_page[7:0], 8'h10 + 8'(k));
        end
        bus_wr(16'hD1F6, 8'h2A);
        bus_wr(16'hD1ED, 8'h5A);
        bus_wr(16'hD1E3, 8'h10);
        chk({ram_en, ram_page}, 13'h1A17);
        chk({prn_data, rom_bank}, 16'h5A10);
    endtask : test_latch

    task automatic test_midreset();
        @(posedge clk);
        arst_n <= 1'b0;
        @(posedge clk);
        arst_n <= 1'b1;
        wait_clk(2);
        chk({ram_en, ram_page}, 13'h0000);
        chk({prn_data, rom_bank}, 16'h0000);
    endtask : test_midreset

    task automatic test_acia();
        for (int k = 0; k < 4; k++) bus_wr(16'hD1C0 + 16'(k + 4 * (k + 1)), 8'hA0 + 8'(k));
        for (int k = 0; k < 4; k++) begin
            bus_rd(16'hD1C0 + 16'(k + 4 * (7 - k)), v);
            chk(v, 8'hA0 + 8'(k));
        end
    endtask : test_acia

    task automatic test_modem();
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            m_dsr <= i[0];
            m_dcd <= i[1];
            m_cts <= i[2];
            wait_clk(4);
            bus_rd(16'hD1E3, v);
            chk(v, 8'(i));
            bus_rd(16'hD1FF, v);
            chk(v, 8'(i));
            chk({dsr_n, cts_n, dcd_n}, 3'h0);
        end
        @(posedge clk);
        {m_cts, m_dcd, m_dsr} <= 3'b010;
        wait_clk(4);
        bus_rd(16'hD1E3, v);
        chk(v, 8'h02);
    endtask : test_modem

    task automatic test_irq();
        @(posedge clk);
        {m_cts, m_dcd, m_dsr} <= 3'b000;
        wait_clk(4);
        bus_wr(16'hD101, 8'h07);
        bus_wr(16'hD102, 8'h00);
        @(posedge clk);
        prn_irq <= 1'b1;
        wait_clk(4);
        bus_rd(16'hD1E3, v);
        chk(v, 8'h18);
        bus_rd(16'hD100, v);
        chk({v, 7'h0, irq}, 16'h0200);
        bus_wr(16'hD102, 8'h02);
        wait_clk(2);
        chk(irq, 1'b1);
        bus_wr(16'hD101, 8'h02);
        wait_clk(2);
        bus_rd(16'hD100, v);
        chk({v, 7'h0, irq}, 16'h0000);
        @(posedge clk);
        prn_irq <= 1'b0;
        a_req   <= 1'b1;
        wait_clk(4);
        bus_rd(16'hD1FF, v);
        chk(v, 8'h10);
        bus_wr(16'hD102, 8'h04);
        wait_clk(2);
        chk(irq, 1'b1);
        bus_wr(16'hD101, 8'h04);
        wait_clk(2);
        chk(irq, 1'b0);
    endtask : test_irq

    task automatic finish_test();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    // bound well above the roughly 230 cycles the tests need
    initial begin
        #(6000 * 50);
        num_errors++;
        finish_test();
    end

    initial begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        wait_clk(3);
        test_reset();
        test_ram();
        test_latch();
        test_midreset();
        test_acia();
        test_modem();
        test_irq();
        finish_test();
    end
endmodule : tb
`default_nettype wire
